/* File: msi_modem_serial.sv */
// Notes on behaviour
// - Jumper picks code pair; receiver lower.
// - Busy and done driven by flag function.
// - Mask bits 1/0 gate done interrupts.
// - Receiver pulse clears break indicator.
// - Receiver read A returns character, high zero.
// - Transmitter write A loads transmit buffer.
// - Receiver read B returns four line statuses.
// - Break indicator sticks until receiver pulse.
// - Receiver write B sets terminal ready.
// - Reception runs without start; busy unused.
// - Received character clears busy, sets done.
// - Start while off turns on, raises RTS.
// - Send only after clear-to-send; buffer clears.
// - Sent character clears busy, sets done.
// - Stays on while busy or done set.
// - Transmitter clear resets flags, drops RTS.
// - Jumper 10/11 unit transmit; receiver accepts both.
// - Rates 150, 1200 and 1800 baud.
`timescale 1ns/100ps
`default_nettype none
module msi_modem_serial
  import msi_pkg::*;
#(
  parameter int DIV_A = DIV_150,
  parameter int DIV_B = DIV_1200,
  parameter int DIV_C = DIV_1800
) (
  input  wire logic        CLK_I,        // System clock 20 MHz
  input  wire logic        RSTN_I,       // Async reset, active low
  input  wire logic        CODE_SEL_I,   // Jumper: 0 codes 40/41, 1 codes 50/51
  input  wire logic        FRAME11_I,    // Jumper: 1 sends 11-unit frames
  input  wire logic [1:0]  RATE_SEL_I,   // Line rate select
  input  wire logic        IO_STB_I,     // IO instruction strobe
  input  wire logic [5:0]  IO_DEV_I,     // Device code
  input  wire logic [2:0]  IO_XFER_I,    // Transfer kind
  input  wire logic [1:0]  IO_FUNC_I,    // Flag function F
  input  wire logic [15:0] IO_DATA_I,    // Accumulator out
  output logic      [15:0] IO_DATA_O,    // Accumulator in
  input  wire logic        MASK_LOAD_I,  // Priority mask load strobe
  input  wire logic [15:0] MASK_I,       // Priority mask word
  output logic             REC_BUSY_O,   // Receiver busy
  output logic             REC_DONE_O,   // Receiver done
  output logic             XMT_BUSY_O,   // Transmitter busy
  output logic             XMT_DONE_O,   // Transmitter done
  output logic             REC_IRQ_O,    // Receiver interrupt request
  output logic             XMT_IRQ_O,    // Transmitter interrupt request
  input  wire logic        RXD_I,        // Received data line
  output logic             TXD_O,        // Transmitted data line
  output logic             RTS_O,        // Request to send
  input  wire logic        CTS_I,        // Clear to send
  output logic             DTR_O,        // Data terminal ready
  input  wire logic        DCD_I,        // Carrier detected
  input  wire logic        DSR_I,        // Data set ready
  input  wire logic        RI_I          // Ring indicator
);

  // ****************************************
  // Oversample tick
  // ****************************************
  logic tick;
  msi_rate_tick #(
    .DIV_A (DIV_A),
    .DIV_B (DIV_B),
    .DIV_C (DIV_C)
  ) u_tick (
    .clk_i      (CLK_I),
    .rstn_i     (RSTN_I),
    .rate_sel_i (RATE_SEL_I),
    .tick_o     (tick)
  );

  // ****************************************
  // Instruction decode
  // ****************************************
  logic         rec_sel, xmt_sel;
  msi_func_type func;
  always_comb begin
    rec_sel = IO_STB_I && (IO_DEV_I == (CODE_SEL_I ? DEV_REC_HI : DEV_REC_LO));
    xmt_sel = IO_STB_I && (IO_DEV_I == (CODE_SEL_I ? DEV_XMT_HI : DEV_XMT_LO));
    func    = msi_func_type'(IO_FUNC_I);
  end

  // ****************************************
  // Register state
  // ****************************************
  logic         rec_busy_r,  rec_busy_nxt,  rec_done_r,  rec_done_nxt;
  logic         xmt_busy_r,  xmt_busy_nxt,  xmt_done_r,  xmt_done_nxt;
  logic         rec_dis_r,   rec_dis_nxt,   xmt_dis_r,   xmt_dis_nxt;
  logic         brk_r,       brk_nxt,       dtr_r,       dtr_nxt;
  logic [7:0]   rbuf_r,      rbuf_nxt;
  logic [7:0]   tbuf_r,      tbuf_nxt;
  logic         tfull_r,     tfull_nxt;
  logic [15:0]  dout_r,      dout_nxt;
  msi_rx_type   rx_st_r,     rx_st_nxt;
  logic [2:0]   rx_ovs_r,    rx_ovs_nxt;
  logic [2:0]   rx_bit_r,    rx_bit_nxt;
  logic [7:0]   rx_sh_r,     rx_sh_nxt;
  msi_tx_type   tx_st_r,     tx_st_nxt;
  logic [2:0]   tx_ovs_r,    tx_ovs_nxt;
  logic [3:0]   tx_bit_r,    tx_bit_nxt;
  logic [10:0]  tx_sh_r,     tx_sh_nxt;
  logic         rx_done_ev,  rx_brk_ev,     tx_done_ev,  tx_start_ok;

  // ****************************************
  // Receiver
  // ****************************************
  always_comb begin
    rx_st_nxt  = rx_st_r;
    rx_ovs_nxt = rx_ovs_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt  = rx_sh_r;
    rbuf_nxt   = rbuf_r;
    rx_done_ev = 1'b0;
    rx_brk_ev  = 1'b0;
    if (tick) begin
      rx_ovs_nxt = rx_ovs_r + 3'h1;
      case (rx_st_r)
        RX_IDLE: begin
          rx_ovs_nxt = 3'h0;
          if (!RXD_I) begin
            rx_st_nxt = RX_START;
          end
        end
        RX_START: begin
          // Mid start bit check rejects short glitches
          if (rx_ovs_r == OVS_MID) begin
            rx_ovs_nxt = 3'h0;
            rx_bit_nxt = 3'h0;
            rx_st_nxt  = RXD_I ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_ovs_r == OVS_LAST) begin
            rx_sh_nxt  = {RXD_I, rx_sh_r[7:1]};
            rx_bit_nxt = rx_bit_r + 3'h1;
            if (rx_bit_r == DATA_LAST) begin
              rx_st_nxt = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // One stop bit is checked, so either frame length passes
          if (rx_ovs_r == OVS_LAST) begin
            rbuf_nxt   = rx_sh_r;
            rx_done_ev = 1'b1;
            if (!RXD_I) begin
              rx_brk_ev = (rx_sh_r == 8'h00);
              rx_st_nxt = RX_HOLD;
            end else begin
              rx_st_nxt = RX_IDLE;
            end
          end
        end
        RX_HOLD: begin
          // Wait for mark so an open line gives one event only
          if (RXD_I) begin
            rx_st_nxt = RX_IDLE;
          end
        end
        default: begin
          rx_st_nxt = RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  always_comb begin
    tx_st_nxt   = tx_st_r;
    tx_ovs_nxt  = tx_ovs_r;
    tx_bit_nxt  = tx_bit_r;
    tx_sh_nxt   = tx_sh_r;
    tx_done_ev  = 1'b0;
    tx_start_ok = 1'b0;
    case (tx_st_r)
      TX_OFF: begin
        if (xmt_busy_r) begin
          tx_st_nxt = TX_READY;
        end
      end
      TX_READY: begin
        if (!(xmt_busy_r || xmt_done_r)) begin
          tx_st_nxt = TX_OFF;
        end else if (xmt_busy_r && tfull_r && CTS_I) begin
          tx_start_ok = 1'b1;
          tx_sh_nxt   = {2'b11, tbuf_r, 1'b0};
          tx_ovs_nxt  = 3'h0;
          tx_bit_nxt  = 4'h0;
          tx_st_nxt   = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tick) begin
          tx_ovs_nxt = tx_ovs_r + 3'h1;
          if (tx_ovs_r == OVS_LAST) begin
            tx_sh_nxt  = {1'b1, tx_sh_r[10:1]};
            tx_bit_nxt = tx_bit_r + 4'h1;
            if (tx_bit_r == (FRAME11_I ? FRAME11_LAST : FRAME10_LAST)) begin
              tx_done_ev = 1'b1;
              tx_st_nxt  = TX_READY;
            end
          end
        end
      end
      default: begin
        tx_st_nxt = TX_OFF;
      end
    endcase
    if (xmt_sel && (func == FN_CLEAR)) begin
      tx_st_nxt = TX_OFF;
    end
  end

  // ****************************************
  // Flags, buffers and IO transfers
  // ****************************************
  always_comb begin
    rec_busy_nxt = rec_busy_r;
    rec_done_nxt = rec_done_r;
    xmt_busy_nxt = xmt_busy_r;
    xmt_done_nxt = xmt_done_r;
    rec_dis_nxt  = rec_dis_r;
    xmt_dis_nxt  = xmt_dis_r;
    brk_nxt      = brk_r;
    dtr_nxt      = dtr_r;
    tbuf_nxt     = tbuf_r;
    tfull_nxt    = tfull_r;
    dout_nxt     = dout_r;
    if (MASK_LOAD_I) begin
      rec_dis_nxt = MASK_I[MASK_REC_BIT];
      xmt_dis_nxt = MASK_I[MASK_XMT_BIT];
    end
    if (tx_start_ok) begin
      tbuf_nxt  = 8'h00;
      tfull_nxt = 1'b0;
    end
    if (rec_sel) begin
      if (msi_xfer_type'(IO_XFER_I) == XF_IN_A) begin
        dout_nxt = {8'h00, rbuf_r};
      end else if (msi_xfer_type'(IO_XFER_I) == XF_IN_B) begin
        dout_nxt = 16'h0000;
        dout_nxt[ST_CARRIER] = DCD_I;
        dout_nxt[ST_DSR]     = DSR_I;
        dout_nxt[ST_RING]    = RI_I;
        dout_nxt[ST_BREAK]   = brk_r;
      end else if (msi_xfer_type'(IO_XFER_I) == XF_OUT_B) begin
        dtr_nxt = IO_DATA_I[AC_DTR_BIT];
      end
      case (func)
        FN_START: begin
          rec_busy_nxt = 1'b1;
          rec_done_nxt = 1'b0;
        end
        FN_CLEAR: begin
          rec_busy_nxt = 1'b0;
          rec_done_nxt = 1'b0;
        end
        FN_PULSE: begin
          brk_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (xmt_sel) begin
      if (msi_xfer_type'(IO_XFER_I) == XF_OUT_A) begin
        tbuf_nxt  = IO_DATA_I[7:0];
        tfull_nxt = 1'b1;
      end
      case (func)
        FN_START: begin
          xmt_busy_nxt = 1'b1;
          xmt_done_nxt = 1'b0;
        end
        FN_CLEAR: begin
          xmt_busy_nxt = 1'b0;
          xmt_done_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    // Hardware events win over a software clear in the same cycle
    if (rx_done_ev) begin
      rec_busy_nxt = 1'b0;
      rec_done_nxt = 1'b1;
    end
    if (rx_brk_ev) begin
      brk_nxt = 1'b1;
    end
    if (tx_done_ev) begin
      xmt_busy_nxt = 1'b0;
      xmt_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      {rec_busy_r, rec_done_r, xmt_busy_r, xmt_done_r} <= 4'h0;
      {rec_dis_r, xmt_dis_r, brk_r, dtr_r, tfull_r}   <= 5'h00;
      {rbuf_r, tbuf_r, dout_r}                        <= 32'h0000_0000;
      {rx_ovs_r, rx_bit_r, rx_sh_r}                   <= 14'h0000;
      {tx_ovs_r, tx_bit_r, tx_sh_r}                   <= 18'h007ff;
      rx_st_r                                         <= RX_IDLE;
      tx_st_r                                         <= TX_OFF;
    end else begin
      {rec_busy_r, rec_done_r, xmt_busy_r, xmt_done_r} <= {rec_busy_nxt, rec_done_nxt, xmt_busy_nxt, xmt_done_nxt};
      {rec_dis_r, xmt_dis_r, brk_r, dtr_r, tfull_r}   <= {rec_dis_nxt, xmt_dis_nxt, brk_nxt, dtr_nxt, tfull_nxt};
      {rbuf_r, tbuf_r, dout_r}                        <= {rbuf_nxt, tbuf_nxt, dout_nxt};
      {rx_ovs_r, rx_bit_r, rx_sh_r}                   <= {rx_ovs_nxt, rx_bit_nxt, rx_sh_nxt};
      {tx_ovs_r, tx_bit_r, tx_sh_r}                   <= {tx_ovs_nxt, tx_bit_nxt, tx_sh_nxt};
      rx_st_r                                         <= rx_st_nxt;
      tx_st_r                                         <= tx_st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    IO_DATA_O  = dout_r;
    REC_BUSY_O = rec_busy_r;
    REC_DONE_O = rec_done_r;
    XMT_BUSY_O = xmt_busy_r;
    XMT_DONE_O = xmt_done_r;
    REC_IRQ_O  = rec_done_r && !rec_dis_r;
    XMT_IRQ_O  = xmt_done_r && !xmt_dis_r;
    TXD_O      = (tx_st_r == TX_SEND) ? tx_sh_r[0] : 1'b1;
    RTS_O      = (tx_st_r != TX_OFF);
    DTR_O      = dtr_r;
  end

endmodule // msi_modem_serial
`default_nettype wire

/* File: msi_pkg.sv */
package msi_pkg;

  // ****************************************
  // Clock and line rates
  // ****************************************
  localparam int CLK_HZ    = 20_000_000;
  localparam int OVS       = 8;
  localparam int RATE_150  = 150;
  localparam int RATE_1200 = 1200;
  localparam int RATE_1800 = 1800;
  localparam int DIV_150   = CLK_HZ / (RATE_150 * OVS);
  localparam int DIV_1200  = CLK_HZ / (RATE_1200 * OVS);
  localparam int DIV_1800  = CLK_HZ / (RATE_1800 * OVS);

  localparam logic [1:0] RATE_SEL_150  = 2'h0;
  localparam logic [1:0] RATE_SEL_1200 = 2'h1;
  localparam logic [1:0] RATE_SEL_1800 = 2'h2;

  // ****************************************
  // Sample and frame counts
  // ****************************************
  localparam logic [2:0] OVS_LAST   = 3'h7;
  localparam logic [2:0] OVS_MID    = 3'h3;
  localparam logic [2:0] DATA_LAST  = 3'h7;
  localparam logic [3:0] FRAME10_LAST = 4'h9;
  localparam logic [3:0] FRAME11_LAST = 4'ha;

  // ****************************************
  // Device codes (octal 40/41 and 50/51)
  // ****************************************
  localparam logic [5:0] DEV_REC_LO = 6'h20;
  localparam logic [5:0] DEV_XMT_LO = 6'h21;
  localparam logic [5:0] DEV_REC_HI = 6'h28;
  localparam logic [5:0] DEV_XMT_HI = 6'h29;

  // ****************************************
  // Accumulator and mask bit positions
  // ****************************************
  localparam int AC_DTR_BIT   = 0;
  localparam int MASK_REC_BIT = 1;
  localparam int MASK_XMT_BIT = 0;
  localparam int ST_CARRIER   = 3;
  localparam int ST_DSR       = 2;
  localparam int ST_RING      = 1;
  localparam int ST_BREAK     = 0;

  // ****************************************
  // Transfer and flag functions
  // ****************************************
  typedef enum logic [2:0] {
    XF_NONE  = 3'b000,
    XF_IN_A  = 3'b001,
    XF_OUT_A = 3'b010,
    XF_IN_B  = 3'b011,
    XF_OUT_B = 3'b100
  } msi_xfer_type;

  typedef enum logic [1:0] {
    FN_NONE  = 2'b00,
    FN_START = 2'b01,
    FN_CLEAR = 2'b10,
    FN_PULSE = 2'b11
  } msi_func_type;

  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_STOP  = 3'b011,
    RX_HOLD  = 3'b100
  } msi_rx_type;

  typedef enum logic [1:0] {
    TX_OFF   = 2'b00,
    TX_READY = 2'b01,
    TX_SEND  = 2'b10
  } msi_tx_type;

endpackage

/* File: msi_rate_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module msi_rate_tick
  import msi_pkg::*;
#(
  parameter int DIV_A = DIV_150,
  parameter int DIV_B = DIV_1200,
  parameter int DIV_C = DIV_1800
) (
  input  wire logic       clk_i,      // System clock
  input  wire logic       rstn_i,     // Async reset, active low
  input  wire logic [1:0] rate_sel_i, // Line rate select
  output logic            tick_o      // Oversample tick pulse
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] reload;

  always_comb begin
    if (rate_sel_i == RATE_SEL_150) begin
      reload = 16'(DIV_A - 1);
    end else if (rate_sel_i == RATE_SEL_1800) begin
      reload = 16'(DIV_C - 1);
    end else begin
      reload = 16'(DIV_B - 1);
    end
    tick_o  = (cnt_r == 16'h0000);
    cnt_nxt = tick_o ? reload : cnt_r - 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule // msi_rate_tick
`default_nettype wire

/* File: msi_modem_serial_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module msi_modem_serial_asserts
  import msi_pkg::*;
(
  input wire logic        CLK_I,       // Clock
  input wire logic        RSTN_I,      // Reset
  input wire logic        CODE_SEL_I,  // Code jumper
  input wire logic        IO_STB_I,    // Strobe
  input wire logic [5:0]  IO_DEV_I,    // Device
  input wire logic [2:0]  IO_XFER_I,   // Transfer
  input wire logic [1:0]  IO_FUNC_I,   // Function
  input wire logic [15:0] IO_DATA_I,   // Write data
  input wire logic [15:0] IO_DATA_O,   // Read data
  input wire logic        MASK_LOAD_I, // Mask load
  input wire logic [15:0] MASK_I,      // Mask
  input wire logic        REC_BUSY_O,  // Rx busy
  input wire logic        REC_DONE_O,  // Rx done
  input wire logic        XMT_BUSY_O,  // Tx busy
  input wire logic        XMT_DONE_O,  // Tx done
  input wire logic        REC_IRQ_O,   // Rx irq
  input wire logic        XMT_IRQ_O,   // Tx irq
  input wire logic        TXD_O,       // Tx line
  input wire logic        RTS_O,       // Request
  input wire logic        CTS_I,       // Clear
  input wire logic        DTR_O        // Ready
);
  // ****************
  // Mask copy and decode
  // ****************
  logic rdis_r, xdis_r, rdis_nxt, xdis_nxt, rec_op, xmt_op;
  always_comb begin
    rdis_nxt = MASK_LOAD_I ? MASK_I[MASK_REC_BIT] : rdis_r;
    xdis_nxt = MASK_LOAD_I ? MASK_I[MASK_XMT_BIT] : xdis_r;
    rec_op = IO_STB_I && IO_DEV_I == (CODE_SEL_I ? DEV_REC_HI : DEV_REC_LO);
    xmt_op = IO_STB_I && IO_DEV_I == (CODE_SEL_I ? DEV_XMT_HI : DEV_XMT_LO);
  end
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdis_r <= 1'b0;
      xdis_r <= 1'b0;
    end else begin
      rdis_r <= rdis_nxt;
      xdis_r <= xdis_nxt;
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // ****************
  // Properties
  // ****************
  irq_rec_a: assert property (REC_IRQ_O == (REC_DONE_O && !rdis_r))
    else $error("rx irq wrong");
  irq_xmt_a: assert property (XMT_IRQ_O == (XMT_DONE_O && !xdis_r))
    else $error("tx irq wrong");
  start_busy_a: assert property (xmt_op && IO_FUNC_I == FN_START && !XMT_BUSY_O |=> XMT_BUSY_O && !XMT_DONE_O)
    else $error("start flags wrong");
  clear_off_a: assert property (xmt_op && IO_FUNC_I == FN_CLEAR && !XMT_BUSY_O |=> !XMT_DONE_O ##1 !RTS_O)
    else $error("clear left tx on");
  rts_hold_a: assert property ((XMT_BUSY_O || XMT_DONE_O) [*2] |-> RTS_O)
    else $error("rts dropped");
  cts_first_a: assert property ($fell(TXD_O) |-> RTS_O && $past(CTS_I))
    else $error("sent without cts");
  idle_mark_a: assert property (!XMT_BUSY_O |-> TXD_O)
    else $error("line not marking");
  done_sent_a: assert property ($rose(XMT_DONE_O) |-> !XMT_BUSY_O && TXD_O && $past(TXD_O))
    else $error("tx done wrong");
  rx_done_a: assert property ($rose(REC_DONE_O) |-> !REC_BUSY_O)
    else $error("rx busy kept");
  read_a_zero_a: assert property (rec_op && IO_XFER_I == XF_IN_A |=> IO_DATA_O[15:8] == 8'h00)
    else $error("read high not zero");
  dtr_write_a: assert property (rec_op && IO_XFER_I == XF_OUT_B |=> DTR_O == $past(IO_DATA_I[AC_DTR_BIT]))
    else $error("dtr wrong");
  cover property ($rose(XMT_DONE_O));
  cover property ($rose(REC_DONE_O));
  cover property (rec_op && IO_FUNC_I == FN_PULSE);
endmodule // msi_modem_serial_asserts
bind msi_modem_serial msi_modem_serial_asserts u_chk (
  .CLK_I, .RSTN_I, .CODE_SEL_I, .IO_STB_I, .IO_DEV_I, .IO_XFER_I, .IO_FUNC_I, .IO_DATA_I, .IO_DATA_O,
  .MASK_LOAD_I, .MASK_I, .REC_BUSY_O, .REC_DONE_O, .XMT_BUSY_O, .XMT_DONE_O, .REC_IRQ_O, .XMT_IRQ_O,
  .TXD_O, .RTS_O, .CTS_I, .DTR_O
);
`default_nettype wire

/* File: msi_modem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module msi_modem_model (
  input  wire logic        clk_i, // Clock
  input  wire logic        rts_i, // Request to send
  input  wire logic        txd_i, // Line from device
  input  wire logic [15:0] bit_i, // Cycles per bit
  input  wire logic [7:0]  dly_i, // Clear delay
  output logic             cts_o, // Clear to send
  output logic             rxd_o  // Line to device
);
  // ****************
  // Handshake and line
  // ****************
  logic [8:0] rx_q[$];
  logic [7:0] d;
  initial begin
    cts_o = 1'b0;
    rxd_o = 1'b1;
  end
  always @(negedge clk_i) begin
    if (rts_i && !cts_o)
      repeat (dly_i) @(negedge clk_i);
    cts_o <= rts_i;
  end
  // Samples mid-bit; stop level kept above the data
  always begin
    @(negedge txd_i);
    repeat (bit_i / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_i) @(negedge clk_i);
      d[i] = txd_i;
    end
    repeat (bit_i) @(negedge clk_i);
    rx_q.push_back({txd_i, d});
  end
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (bit_i) @(negedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
endmodule // msi_modem_model
`default_nettype wire

/* File: modem_serial_interface_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module modem_serial_interface_bench
  import msi_pkg::*;
;
  localparam int DA = 2;
  localparam int DB = 3;
  localparam int DC = 4;
  logic        clk, rstn, code_sel, frame11, stb, mask_ld, rbusy, rdone, xbusy, xdone;
  logic        rirq, xirq, rxd, txd, rts, cts, dtr, dcd, dsr, ri;
  logic [1:0]  rate_sel, func;
  logic [2:0]  xfer;
  logic [5:0]  dev, rc, xc;
  logic [7:0]  dly;
  logic [15:0] din, dout, mask, bitc;
  logic [7:0]  exp_rx[$];
  logic [8:0]  exp_tx[$];
  int          errors, total_checks, cyc, brk, seed, i;
  msi_modem_serial #(.DIV_A(DA), .DIV_B(DB), .DIV_C(DC)) u_dut (
    .CLK_I(clk), .RSTN_I(rstn), .CODE_SEL_I(code_sel), .FRAME11_I(frame11), .RATE_SEL_I(rate_sel),
    .IO_STB_I(stb), .IO_DEV_I(dev), .IO_XFER_I(xfer), .IO_FUNC_I(func), .IO_DATA_I(din),
    .IO_DATA_O(dout), .MASK_LOAD_I(mask_ld), .MASK_I(mask), .REC_BUSY_O(rbusy), .REC_DONE_O(rdone),
    .XMT_BUSY_O(xbusy), .XMT_DONE_O(xdone), .REC_IRQ_O(rirq), .XMT_IRQ_O(xirq), .RXD_I(rxd),
    .TXD_O(txd), .RTS_O(rts), .CTS_I(cts), .DTR_O(dtr), .DCD_I(dcd), .DSR_I(dsr), .RI_I(ri)
  );
  msi_modem_model u_modem (
    .clk_i(clk), .rts_i(rts), .txd_i(txd), .bit_i(bitc), .dly_i(dly), .cts_o(cts), .rxd_o(rxd)
  );
  // ****************
  // Clock, timeout and tasks
  // ****************
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic io(input logic [5:0] d, input msi_xfer_type x, input msi_func_type f, input logic [15:0] v);
    @(negedge clk);
    {stb, dev, xfer, func, din} = {1'b1, d, x, f, v};
    @(negedge clk);
    stb = 1'b0;
  endtask
  task automatic set_mask(input logic [15:0] m);
    @(negedge clk);
    {mask, mask_ld} = {m, 1'b1};
    @(negedge clk);
    mask_ld = 1'b0;
  endtask
  task automatic rx_one(input logic [7:0] v, input int n, input logic dis);
    int k;
    k = 0;
    set_mask({14'h0, dis, 1'b0});
    if (n == 11)
      io(rc, XF_NONE, FN_START, 16'h0);
    exp_rx.push_back(v);
    u_modem.send({2'b11, v, 1'b0}, n);
    while (rdone !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    chk(16'({rbusy, rirq}), 16'({1'b0, !dis}));
    io(rc, XF_IN_A, FN_CLEAR, 16'hffff);
    chk(dout, {8'h00, exp_rx.pop_front()});
    chk(16'(rdone), 16'h0);
  endtask
  task automatic tx_one(input logic [7:0] v);
    int n, m;
    {n, m} = 0;
    exp_tx.push_back({1'b1, v});
    io(xc, XF_OUT_A, FN_START, {8'hff, v});
    while (txd === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    while (xdone !== 1'b1 && m < 3000) begin
      @(negedge clk);
      m++;
    end
    chk(16'((m + bitc / 8 + 1) / bitc), frame11 ? 16'hb : 16'ha);
    chk(16'(u_modem.rx_q.pop_front()), 16'(exp_tx.pop_front()));
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    seed = 32'h5cf126bc;
    {clk, rstn, code_sel, frame11, stb, mask_ld, dcd, dsr, ri} = 9'h0;
    {dev, xfer, func, din, mask, dly} = 0;
    rate_sel = RATE_SEL_1200;
    bitc = 16'(8 * DB);
    rc = DEV_REC_LO;
    xc = DEV_XMT_LO;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 8; i++) begin
      {dcd, dsr, ri} = 3'(i);
      io(rc, XF_IN_B, FN_NONE, 16'h0);
      chk(dout, {12'h0, 3'(i), 1'b0});
      io(rc, XF_OUT_B, FN_NONE, {15'h0, i[0]});
      chk(16'(dtr), 16'(i[0]));
    end
    for (i = 0; i < 6; i++)
      rx_one(8'($random(seed)), 10 + i % 2, i[1]);
    brk = 1;
    u_modem.send(11'h000, 11);
    io(rc, XF_NONE, FN_CLEAR, 16'h0);
    rx_one(8'($random(seed)), 10, 1'b0);
    io(rc, XF_IN_B, FN_NONE, 16'h0);
    chk(dout, {12'h0, dcd, dsr, ri, 1'(brk)});
    io(rc, XF_NONE, FN_PULSE, 16'h0);
    brk = 0;
    io(rc, XF_IN_B, FN_NONE, 16'h0);
    chk(dout, {12'h0, dcd, dsr, ri, 1'(brk)});
    for (i = 0; i < 6; i++) begin
      {code_sel, frame11, rate_sel} = {i[0], i >= 3, 2'(i % 3)};
      rc = code_sel ? DEV_REC_HI : DEV_REC_LO;
      xc = code_sel ? DEV_XMT_HI : DEV_XMT_LO;
      bitc = 16'(8 * (i % 3 == 0 ? DA : i % 3 == 1 ? DB : DC));
      dly = 8'($random(seed)) & 8'h0f;
      set_mask({14'h0, 1'b0, i[1]});
      io(xc ^ 6'h08, XF_NONE, FN_START, 16'h0);
      chk(16'(xbusy), 16'h0);
      tx_one(8'($random(seed)));
      tx_one(8'($random(seed)));
      chk({14'h0, rts, xirq}, {14'h0, 1'b1, ~i[1]});
      io(xc, XF_NONE, FN_CLEAR, 16'h0);
      @(negedge clk);
      chk({14'h0, rts, xdone}, 16'h0);
    end
    io(xc, XF_NONE, FN_START, 16'h0);
    repeat (12 * bitc) @(negedge clk);
    chk({15'h0, xbusy}, 16'h1);
    chk(16'(u_modem.rx_q.size()), 16'h0);
    stop_test();
  end
endmodule // modem_serial_interface_bench
`default_nettype wire
